// ---- verilog/fcmd_params.svh ----
// fcmd_params.svh: command codes, status bit positions and counts
// assumes: included by the sequencer and top-level design files of the command interpreter
`ifndef FCMD_PARAMS_SVH
`define FCMD_PARAMS_SVH

// ****************************************************************
// command codes
// ****************************************************************
`define FCMD_READ_ARRAY  8'hFF
`define FCMD_READ_STATUS 8'h70
`define FCMD_READ_IDENT  8'h90
`define FCMD_READ_QUERY  8'h98
`define FCMD_CLEAR_SR    8'h50
`define FCMD_WORD_PROG   8'h40
`define FCMD_BUF_PROG    8'hE8
`define FCMD_CONFIRM     8'hD0
`define FCMD_FACT_SETUP  8'h80
`define FCMD_ERASE       8'h20
`define FCMD_SUSPEND     8'hB0
`define FCMD_LOCK_SETUP  8'h60
`define FCMD_LOCK        8'h01
`define FCMD_LOCK_DOWN   8'h2F
`define FCMD_OTP_PROG    8'hC0
`define FCMD_SET_RCR     8'h03
`define FCMD_BLANK       8'hBC
`define FCMD_EFI         8'hEB

// ****************************************************************
// status layout, reset values, counts
// ****************************************************************
`define FCMD_SR_RESET    8'h80
`define FCMD_SR_READY    7
`define FCMD_SR_ESUSP    6
`define FCMD_SR_EERR     5
`define FCMD_SR_PERR     4
`define FCMD_SR_PSUSP    2
`define FCMD_RCR_MSB     16
`define FCMD_RCR_LSB     1
`define FCMD_BUF_WORDS   512
`define FCMD_OP_CYCLES   64
`define FCMD_SYNC_STAGES 3

`endif

// ---- verilog/fcmd_pkg.sv ----
// fcmd_pkg: state and operation types of the command interpreter
// assumes: nothing beyond the language
package fcmd_pkg;

  typedef enum logic [12:0] {
    D_IDLE  = 13'h0001,
    D_PROG  = 13'h0002,
    D_BCNT  = 13'h0004,
    D_BDATA = 13'h0008,
    D_BCONF = 13'h0010,
    D_FACT  = 13'h0020,
    D_ERASE = 13'h0040,
    D_LOCK  = 13'h0080,
    D_OTP   = 13'h0100,
    D_BLANK = 13'h0200,
    D_ESUB  = 13'h0400,
    D_ECNT  = 13'h0800,
    D_FMODE = 13'h1000
  } fcmd_dec_t;

  typedef enum logic [3:0] {
    RD_ARRAY  = 4'h1,
    RD_STATUS = 4'h2,
    RD_IDENT  = 4'h4,
    RD_QUERY  = 4'h8
  } fcmd_rd_t;

  typedef enum logic [4:0] {
    OP_WORD  = 5'h01,
    OP_BUF   = 5'h02,
    OP_ERASE = 5'h04,
    OP_OTP   = 5'h08,
    OP_BLANK = 5'h10
  } fcmd_op_t;

  typedef enum logic [2:0] {
    LK_LOCK   = 3'h1,
    LK_UNLOCK = 3'h2,
    LK_DOWN   = 3'h4
  } fcmd_lock_t;

endpackage : fcmd_pkg

// ---- verilog/fcmd_seq_if.sv ----
// fcmd_seq_if: decoder to sequencer start, suspend and status wires
// assumes: both ends on clock_i
`timescale 1ns/1ps
interface fcmd_seq_if;
  import fcmd_pkg::*;
  logic     start;
  fcmd_op_t op;
  logic     suspend;
  logic     resume;
  logic     active;
  logic     running;
  logic     susp_prog;
  logic     susp_erase;
  logic     done;
  modport dec (output start, op, suspend, resume,
               input active, running, susp_prog, susp_erase, done);
  modport seq (input start, op, suspend, resume,
               output active, running, susp_prog, susp_erase, done);
endinterface : fcmd_seq_if

// ---- verilog/fcmd_seq.sv ----
// fcmd_seq: timed program/erase sequencer with suspend and resume
// assumes: start only when idle; asynchronous reset aborts the job
`timescale 1ns/1ps
`include "fcmd_params.svh"
module fcmd_seq
  import fcmd_pkg::*;
#(
  parameter int OP_CYCLES = `FCMD_OP_CYCLES
) (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  fcmd_seq_if.seq   sif
);
  logic        busy_r;
  logic        susp_r;
  logic        erase_r;
  logic        done_r;
  logic [15:0] cnt_r;

  wire run_w    = busy_r & ~susp_r;
  wire finish_w = run_w & ~sif.suspend & (cnt_r == 16'h0000);

  // ****************************************************************
  // job timer; reset drops the job, leaving its target undefined
  // ****************************************************************
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_r  <= 1'b0;
      susp_r  <= 1'b0;
      erase_r <= 1'b0;
      done_r  <= 1'b0;
      cnt_r   <= 16'h0000;
    end else begin
      done_r <= finish_w;
      if (sif.start && !busy_r) begin
        busy_r  <= 1'b1;
        erase_r <= (sif.op == OP_ERASE);
        cnt_r   <= 16'(OP_CYCLES - 1);
      end else if (run_w && sif.suspend) begin
        susp_r <= 1'b1;
      end else if (susp_r && sif.resume) begin
        susp_r <= 1'b0;
      end else if (finish_w) begin
        busy_r <= 1'b0;
      end else if (run_w) begin
        cnt_r <= cnt_r - 16'h0001;
      end
    end
  end

  assign sif.active     = busy_r;
  assign sif.running    = run_w;
  assign sif.susp_prog  = susp_r & ~erase_r;
  assign sif.susp_erase = susp_r & erase_r;
  assign sif.done       = done_r;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  suspend_holds_a: assert property (
    run_w && sif.suspend |=> susp_r [*3] or (susp_r ##[0:2] sif.resume))
    else $error("suspended job did not stay suspended");
  job_length_a: assert property (
    sif.start && !busy_r && !sif.suspend |=> run_w ##1 run_w)
    else $error("job ended too early");
endmodule : fcmd_seq

// ---- verilog/fcmd_top.sv ----
// fcmd_top: command interpreter of a 16-bit parallel flash device
// assumes: flash pins arrive asynchronously; array, identifier and
// query data are supplied by neighbouring logic on clock_i
`timescale 1ns/1ps
`include "fcmd_params.svh"

// How it works
// - after reset: array read state, status reads 0x80
// - reset floats data outputs and stops any running job
// - reset during program or erase aborts it; target left undefined
// - 0xFF selects array read on all sixteen data lines
// - 0x70 or any program/erase command selects status read
// - 0x90 selects identifier read
// - 0x98 selects query read on the low eight lines
// - error bits only set by hardware; 0x50 clears them
// - 0x40 then one data write programs that word
// - while busy only status read and suspend are accepted
// - 0xE8, count, up to 512 words, then 0xD0 programs buffer
// - 0x80 then 0xD0 enters factory mode; commands then ignored
// - 0x20 then 0xD0 erases; other code sets bits 4,5 and status read
// - 0xB0 suspends job; suspended flag plus ready until resume/reset
// - 0xD0 while suspended resumes the job
// - 0x60 then 0x01 lock, 0xD0 unlock unless locked down, 0x2F down
// - 0xC0 then one write programs the one-time register
// - 0x60 then 0x03 loads read config from address; array read
// - 0xBC then 0xD0 runs a blank check on the block
// - 0xEB, sub-opcode, count minus one, then that many data words
// - command captured when write strobe or chip select rises first
module fcmd_top
  import fcmd_pkg::*;
#(
  parameter int AW        = 25,
  parameter int OP_CYCLES = `FCMD_OP_CYCLES
) (
  input  wire logic          clock_i,
  input  wire logic          rst_n_i,
  input  wire logic          chip_sel_n_i,
  input  wire logic          out_en_n_i,
  input  wire logic          write_en_n_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [15:0]   dq_i,
  input  wire logic [15:0]   array_data_i,
  input  wire logic [15:0]   ident_data_i,
  input  wire logic [7:0]    query_data_i,
  input  wire logic          locked_down_i,
  output logic      [15:0]   dq_o,
  output logic               dq_oe_o,
  output logic      [7:0]    status_o,
  output logic      [3:0]    read_state_o,
  output logic      [15:0]   read_config_reg_o,
  output logic               op_start_o,
  output logic      [4:0]    op_kind_o,
  output logic      [AW-1:0] op_addr_o,
  output logic      [15:0]   op_data_o,
  output logic               buf_wr_o,
  output logic      [8:0]    buf_idx_o,
  output logic      [15:0]   efi_subop_o,
  output logic               lock_req_o,
  output logic      [2:0]    lock_kind_o,
  output logic               fast_factory_program_o
);
  localparam int PW = 3 + AW + 16;
  localparam logic [PW-1:0] PIN_IDLE = {3'h7, {(AW + 16){1'b0}}};

  // ****************************************************************
  // pin synchroniser: three stages, a bit moves when 2 and 3 agree
  // ****************************************************************
  logic [PW-1:0] s1_r;
  logic [PW-1:0] s2_r;
  logic [PW-1:0] s3_r;
  logic [PW-1:0] pin_r;
  logic [PW-1:0] pin_nxt;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_r  <= PIN_IDLE;
      s2_r  <= PIN_IDLE;
      s3_r  <= PIN_IDLE;
      pin_r <= PIN_IDLE;
    end else begin
      s1_r  <= {chip_sel_n_i, out_en_n_i, write_en_n_i, addr_i, dq_i};
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      pin_r <= pin_nxt;
    end
  end

  for (genvar i = 0; i < PW; i++) begin : g_filt
    assign pin_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : pin_r[i];
  end

  wire          ce_n_w = pin_r[PW-1];
  wire          oe_n_w = pin_r[PW-2];
  wire          we_n_w = pin_r[PW-3];
  wire [AW-1:0] addr_w = pin_r[AW+15:16];
  wire [15:0]   data_w = pin_r[15:0];

  // ****************************************************************
  // write cycle capture
  // ****************************************************************
  // end of the cycle is whichever of strobe or select rises first,
  // so the last values seen while both were low are the command
  wire wr_act_w = ~ce_n_w & ~we_n_w & oe_n_w;
  logic          wr_act_r;
  logic [AW-1:0] cap_addr_r;
  logic [15:0]   cap_data_r;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_act_r   <= 1'b0;
      cap_addr_r <= '0;
      cap_data_r <= 16'h0000;
    end else begin
      wr_act_r <= wr_act_w;
      if (wr_act_w) begin
        cap_addr_r <= addr_w;
        cap_data_r <= data_w;
      end
    end
  end

  wire       cmd_evt = wr_act_r & ~wr_act_w;
  wire [7:0] code    = cap_data_r[7:0];

  wire is_read_cmd = (code == `FCMD_READ_ARRAY) | (code == `FCMD_READ_STATUS)
                   | (code == `FCMD_READ_IDENT) | (code == `FCMD_READ_QUERY);

  // ****************************************************************
  // sequencer
  // ****************************************************************
  fcmd_seq_if sif ();

  fcmd_seq #(
    .OP_CYCLES (OP_CYCLES)
  ) u_seq (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .sif     (sif)
  );

  // ****************************************************************
  // command decoder
  // ****************************************************************
  fcmd_dec_t  dec_r;
  fcmd_dec_t  dec_nxt;
  fcmd_rd_t   rd_r;
  fcmd_rd_t   rd_nxt;
  fcmd_op_t   op_nxt;
  fcmd_lock_t lock_nxt;
  logic [8:0] cnt_r;
  logic [8:0] cnt_nxt;
  logic [8:0] idx_r;
  logic [8:0] idx_nxt;
  logic       start_nxt;
  logic       seq_err;
  logic       clr_err;
  logic       lock_nxt_req;
  logic       buf_wr_nxt;
  logic       rcr_load;
  logic       sub_load;
  logic       susp_nxt;
  logic       resume_nxt;
  logic       fact_nxt;
  logic       fact_r;

  always_comb begin
    dec_nxt      = dec_r;
    rd_nxt       = rd_r;
    op_nxt       = OP_WORD;
    lock_nxt     = LK_LOCK;
    cnt_nxt      = cnt_r;
    idx_nxt      = idx_r;
    start_nxt    = 1'b0;
    seq_err      = 1'b0;
    clr_err      = 1'b0;
    lock_nxt_req = 1'b0;
    buf_wr_nxt   = 1'b0;
    rcr_load     = 1'b0;
    sub_load     = 1'b0;
    susp_nxt     = 1'b0;
    resume_nxt   = 1'b0;
    fact_nxt     = fact_r;
    if (!cmd_evt) begin
      dec_nxt = dec_r;
    end else if (fact_r) begin
      // every write is buffer data; no command can leave this mode
      buf_wr_nxt = 1'b1;
      idx_nxt    = idx_r + 9'h001;
    end else if (sif.running) begin
      if (code == `FCMD_READ_STATUS) begin
        rd_nxt = RD_STATUS;
      end else if (code == `FCMD_SUSPEND) begin
        susp_nxt = 1'b1;
        rd_nxt   = RD_STATUS;
      end
    end else begin
      case (dec_r)
        D_IDLE: begin
          if (code == `FCMD_READ_ARRAY) begin
            rd_nxt = RD_ARRAY;
          end else if (code == `FCMD_READ_STATUS) begin
            rd_nxt = RD_STATUS;
          end else if (code == `FCMD_READ_IDENT) begin
            rd_nxt = RD_IDENT;
          end else if (code == `FCMD_READ_QUERY) begin
            rd_nxt = RD_QUERY;
          end else if (code == `FCMD_CLEAR_SR) begin
            clr_err = 1'b1;
          end else if (sif.active) begin
            resume_nxt = (code == `FCMD_CONFIRM);
          end else if (code == `FCMD_WORD_PROG) begin
            dec_nxt = D_PROG;
            rd_nxt  = RD_STATUS;
          end else if (code == `FCMD_BUF_PROG) begin
            dec_nxt = D_BCNT;
            rd_nxt  = RD_STATUS;
          end else if (code == `FCMD_FACT_SETUP) begin
            dec_nxt = D_FACT;
            rd_nxt  = RD_STATUS;
          end else if (code == `FCMD_ERASE) begin
            dec_nxt = D_ERASE;
            rd_nxt  = RD_STATUS;
          end else if (code == `FCMD_LOCK_SETUP) begin
            dec_nxt = D_LOCK;
          end else if (code == `FCMD_OTP_PROG) begin
            dec_nxt = D_OTP;
            rd_nxt  = RD_STATUS;
          end else if (code == `FCMD_BLANK) begin
            dec_nxt = D_BLANK;
            rd_nxt  = RD_STATUS;
          end else if (code == `FCMD_EFI) begin
            dec_nxt = D_ESUB;
            rd_nxt  = RD_STATUS;
          end
        end
        D_PROG: begin
          start_nxt = 1'b1;
          op_nxt    = OP_WORD;
          dec_nxt   = D_IDLE;
        end
        D_OTP: begin
          start_nxt = 1'b1;
          op_nxt    = OP_OTP;
          dec_nxt   = D_IDLE;
        end
        D_ERASE, D_BLANK, D_BCONF: begin
          dec_nxt = D_IDLE;
          rd_nxt  = RD_STATUS;
          if (code == `FCMD_CONFIRM) begin
            start_nxt = 1'b1;
            op_nxt    = (dec_r == D_ERASE) ? OP_ERASE
                      : (dec_r == D_BLANK) ? OP_BLANK : OP_BUF;
          end else begin
            seq_err = 1'b1;
          end
        end
        D_FACT: begin
          if (code == `FCMD_CONFIRM) begin
            fact_nxt = 1'b1;
            dec_nxt  = D_FMODE;
            idx_nxt  = 9'h000;
          end else begin
            seq_err = 1'b1;
            dec_nxt = D_IDLE;
          end
        end
        D_LOCK: begin
          dec_nxt = D_IDLE;
          if (code == `FCMD_LOCK) begin
            lock_nxt_req = 1'b1;
            lock_nxt     = LK_LOCK;
          end else if (code == `FCMD_CONFIRM) begin
            lock_nxt_req = ~locked_down_i;
            lock_nxt     = LK_UNLOCK;
          end else if (code == `FCMD_LOCK_DOWN) begin
            lock_nxt_req = 1'b1;
            lock_nxt     = LK_DOWN;
          end else if (code == `FCMD_SET_RCR) begin
            rcr_load = 1'b1;
            rd_nxt   = RD_ARRAY;
          end else begin
            seq_err = 1'b1;
            rd_nxt  = RD_STATUS;
          end
        end
        D_ESUB: begin
          sub_load = 1'b1;
          dec_nxt  = D_ECNT;
        end
        D_BCNT, D_ECNT: begin
          cnt_nxt = cap_data_r[8:0];
          idx_nxt = 9'h000;
          dec_nxt = D_BDATA;
        end
        D_BDATA: begin
          buf_wr_nxt = 1'b1;
          idx_nxt    = idx_r + 9'h001;
          if (idx_r == cnt_r) begin
            dec_nxt = D_BCONF;
          end
        end
        default: begin
          dec_nxt = D_IDLE;
        end
      endcase
    end
  end

  assign sif.start   = start_nxt;
  assign sif.op      = op_nxt;
  assign sif.suspend = susp_nxt;
  assign sif.resume  = resume_nxt;

  // ****************************************************************
  // status: error bits are sticky, a set beats a same-cycle clear
  // ****************************************************************
  logic perr_r;
  logic eerr_r;
  wire  perr_nxt = (perr_r & ~clr_err) | seq_err;
  wire  eerr_nxt = (eerr_r & ~clr_err) | seq_err;
  logic [7:0] status_w;

  always_comb begin
    status_w                = 8'h00;
    status_w[`FCMD_SR_READY] = ~sif.running;
    status_w[`FCMD_SR_ESUSP] = sif.susp_erase;
    status_w[`FCMD_SR_EERR]  = eerr_r;
    status_w[`FCMD_SR_PERR]  = perr_r;
    status_w[`FCMD_SR_PSUSP] = sif.susp_prog;
  end

  // ****************************************************************
  // read path: output enable only while selected and reading
  // ****************************************************************
  wire        rd_en_w = ~ce_n_w & ~oe_n_w & we_n_w;
  wire [15:0] rd_mux_w = (rd_r == RD_STATUS) ? {8'h00, status_w}
                       : (rd_r == RD_IDENT)  ? ident_data_i
                       : (rd_r == RD_QUERY)  ? {8'h00, query_data_i}
                       : array_data_i;

  // ****************************************************************
  // state registers; asynchronous reset floats the bus
  // ****************************************************************
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dec_r  <= D_IDLE;
      rd_r   <= RD_ARRAY;
      cnt_r  <= 9'h000;
      idx_r  <= 9'h000;
      fact_r <= 1'b0;
      perr_r <= 1'b0;
      eerr_r <= 1'b0;
    end else begin
      dec_r  <= dec_nxt;
      rd_r   <= rd_nxt;
      cnt_r  <= cnt_nxt;
      idx_r  <= idx_nxt;
      fact_r <= fact_nxt;
      perr_r <= perr_nxt;
      eerr_r <= eerr_nxt;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dq_o     <= 16'h0000;
      dq_oe_o  <= 1'b0;
      status_o <= `FCMD_SR_RESET;
    end else begin
      dq_o     <= rd_mux_w;
      dq_oe_o  <= rd_en_w;
      status_o <= status_w;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      op_start_o  <= 1'b0;
      op_kind_o   <= 5'h00;
      buf_wr_o    <= 1'b0;
      buf_idx_o   <= 9'h000;
      lock_req_o  <= 1'b0;
      lock_kind_o <= 3'h0;
    end else begin
      op_start_o  <= start_nxt;
      op_kind_o   <= start_nxt ? op_nxt : op_kind_o;
      buf_wr_o    <= buf_wr_nxt;
      buf_idx_o   <= idx_r;
      lock_req_o  <= lock_nxt_req;
      lock_kind_o <= lock_nxt_req ? lock_nxt : lock_kind_o;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      op_addr_o         <= '0;
      op_data_o         <= 16'h0000;
      read_config_reg_o <= 16'h0000;
      efi_subop_o       <= 16'h0000;
    end else begin
      if (cmd_evt && dec_r != D_IDLE) begin
        op_addr_o <= cap_addr_r;
        op_data_o <= cap_data_r;
      end
      if (rcr_load) begin
        read_config_reg_o <= cap_addr_r[`FCMD_RCR_MSB:`FCMD_RCR_LSB];
      end
      if (sub_load) begin
        efi_subop_o <= cap_data_r;
      end
    end
  end

  assign read_state_o           = rd_r;
  assign fast_factory_program_o = fact_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  logic up_r;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) up_r <= 1'b0;
    else          up_r <= 1'b1;
  end

  reset_state_a: assert property (
    !up_r |-> status_o == `FCMD_SR_RESET && rd_r == RD_ARRAY && !dq_oe_o)
    else $error("wrong state after reset");
  float_out_a: assert property (
    dq_oe_o |-> $past(rd_en_w))
    else $error("data driven without a read cycle");
  read_array_a: assert property (
    cmd_evt && !fact_r && !sif.running && dec_r == D_IDLE
      && code == `FCMD_READ_ARRAY |=> rd_r == RD_ARRAY ##1 dq_o == $past(array_data_i))
    else $error("0xFF did not give array read");
  status_mode_a: assert property (
    sif.start |=> rd_r == RD_STATUS && op_start_o)
    else $error("job start did not select status read");
  err_sticky_a: assert property (
    perr_r && !clr_err |=> perr_r)
    else $error("error bit lost without clear");
  busy_filter_a: assert property (
    sif.running && cmd_evt && !is_read_cmd |=> $stable(dec_r) && !op_start_o)
    else $error("command accepted while busy");
  fact_ignore_a: assert property (
    fact_r |=> fact_r && $stable(rd_r) && !op_start_o)
    else $error("command honoured in factory mode");
  erase_seq_a: assert property (
    cmd_evt && !fact_r && !sif.running && dec_r == D_ERASE && code != `FCMD_CONFIRM
      |=> perr_r && eerr_r && rd_r == RD_STATUS ##1 status_o[5:4] == 2'h3)
    else $error("bad erase confirm not flagged");
  buf_count_a: assert property (
    cmd_evt && !fact_r && dec_r == D_BDATA && idx_r == cnt_r |=> dec_r == D_BCONF)
    else $error("buffer count not honoured");
  ready_flag_a: assert property (
    ##1 status_o[`FCMD_SR_READY] == !$past(sif.running))
    else $error("ready flag does not follow sequencer");

  word_prog_c: cover property (dec_r == D_PROG ##[1:200] op_start_o);
  suspend_c: cover property (sif.susp_erase ##[1:200] !sif.active);
  buf_prog_c: cover property (dec_r == D_BCONF ##[1:200] op_start_o);
endmodule : fcmd_top

// ---- verification/fcmd_host.sv ----
// host bus model: drives select, strobe, address and data pins
// assumes: pins sampled on clock_i through the block's input filter
`timescale 1ns/1ps
module fcmd_host (
  input  wire logic   clock_i,
  output logic        ce_n_o,
  output logic        oe_n_o,
  output logic        we_n_o,
  output logic [24:0] addr_o,
  output logic [15:0] dq_o,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rdata_oe_i
);
  initial begin
    {ce_n_o, oe_n_o, we_n_o} = 3'h7;
    addr_o = 25'h0;
    dq_o = 16'h0000;
  end
  // active level held six clocks, idle level eight, longer than the filter needs
  task automatic wr(input logic [24:0] a, input logic [15:0] d);
    @(posedge clock_i) #1;
    {ce_n_o, we_n_o, addr_o, dq_o} = {2'b00, a, d};
    repeat (6) @(posedge clock_i);
    #1 {ce_n_o, we_n_o} = 2'b11;
    dq_o = ~d; // released bus shows no stale value
    repeat (8) @(posedge clock_i);
    #1;
  endtask : wr
  // read cycle; select and output enable drop so the data bus is driven
  task automatic rd(input logic [24:0] a, output logic [15:0] q, output logic oe);
    @(posedge clock_i) #1;
    {ce_n_o, oe_n_o, addr_o} = {2'b00, a};
    repeat (6) @(posedge clock_i);
    #1 q = rdata_i;
    oe = rdata_oe_i;
    {ce_n_o, oe_n_o} = 2'b11;
    repeat (8) @(posedge clock_i);
    #1;
  endtask : rd
endmodule : fcmd_host

// ---- verification/tb.sv ----
// tb: self-checking bench of the flash command interpreter
// assumes: fcmd_host drives the pins; source data inputs tied
`timescale 1ns/1ps
module tb;
  import fcmd_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        ce_n, oe_n, we_n, dq_oe, bwr, ff;
  logic [24:0] addr, op_addr;
  logic [15:0] dq, read_config_reg, op_data, rdq, sub;
  logic [7:0]  st;
  logic [3:0]  rs;
  logic [4:0]  kind;
  logic [2:0]  lk;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          wr_n      = 0;
  always #12.5 clock_i = ~clock_i;
  // counts buffer word pulses for the buffered and factory scenarios
  always @(posedge clock_i) if (bwr === 1'b1) wr_n++;
  fcmd_host i_host (.clock_i(clock_i), .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n),
    .addr_o(addr), .dq_o(dq), .rdata_i(rdq), .rdata_oe_i(dq_oe));
  fcmd_top #(.OP_CYCLES(64)) i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .chip_sel_n_i(ce_n), .out_en_n_i(oe_n), .write_en_n_i(we_n), .addr_i(addr),
    .dq_i(dq), .array_data_i(16'h1234), .ident_data_i(16'h5678),
    .query_data_i(8'h9A), .locked_down_i(1'b0), .dq_o(rdq), .dq_oe_o(dq_oe),
    .status_o(st), .read_state_o(rs), .read_config_reg_o(read_config_reg), .op_start_o(),
    .op_kind_o(kind), .op_addr_o(op_addr), .op_data_o(op_data), .buf_wr_o(bwr),
    .buf_idx_o(), .efi_subop_o(sub), .lock_req_o(), .lock_kind_o(lk),
    .fast_factory_program_o(ff));
  task automatic chk(input logic [24:0] seen, input logic [24:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wait_ready();
    for (int n = 0; n < 300 && st[7] !== 1'b1; n++) @(posedge clock_i);
  endtask : wait_ready
  task automatic t_reads();
    logic [7:0]  c[4] = '{8'h70, 8'h90, 8'h98, 8'hFF};
    logic [3:0]  e[4] = '{4'h2, 4'h4, 4'h8, 4'h1};
    logic [15:0] v[4] = '{16'h0080, 16'h5678, 16'h009A, 16'h1234};
    logic [15:0] q;
    logic        oe;
    for (int i = 0; i < 4; i++) begin
      i_host.wr(25'h10, {8'h00, c[i]});
      chk(rs, e[i]);
      i_host.rd(25'h10, q, oe);
      chk(q, v[i]);
      chk(oe, 1'b1);
    end
    $display("reads done");
  endtask : t_reads
  task automatic t_seq_err();
    i_host.wr(25'h40, 16'h0020);
    i_host.wr(25'h40, 16'h00FF);
    chk(st & 8'h30, 8'h30);
    chk(rs, 4'h2);
    i_host.wr(25'h0, 16'h0050);
    chk(st, 8'h80);
    $display("sequence error done");
  endtask : t_seq_err
  task automatic t_ops();
    logic [15:0] s[3] = '{16'h0040, 16'h00C0, 16'h00BC};
    logic [15:0] d[3] = '{16'hBEEF, 16'h0055, 16'h00D0};
    logic [4:0]  k[3] = '{5'h01, 5'h08, 5'h10};
    for (int i = 0; i < 3; i++) begin
      i_host.wr(25'h1230 + i, s[i]);
      i_host.wr(25'h1230 + i, d[i]);
      chk(kind, k[i]);
      chk(op_data, d[i]);
      chk(op_addr, 25'h1230 + i);
      chk(st[7], 1'b0);
      chk(rs, 4'h2);
      wait_ready();
      chk(st, 8'h80);
    end
    $display("program ops done");
  endtask : t_ops
  task automatic t_susp();
    i_host.wr(25'h8000, 16'h0020);
    i_host.wr(25'h8000, 16'h00D0);
    i_host.wr(25'h0, 16'h0090);
    chk(rs, 4'h2);
    i_host.wr(25'h0, 16'h00B0);
    chk(st & 8'hC0, 8'hC0);
    i_host.wr(25'h0, 16'h00D0);
    chk(st & 8'hC0, 8'h00);
    wait_ready();
    chk(st, 8'h80);
    $display("suspend done");
  endtask : t_susp
  task automatic t_lock();
    logic [7:0] c[3] = '{8'h01, 8'hD0, 8'h2F};
    for (int i = 0; i < 3; i++) begin
      i_host.wr(25'h20000, 16'h0060);
      i_host.wr(25'h20000, {8'h00, c[i]});
      chk(lk, 3'h1 << i);
    end
    i_host.wr(25'h14B86, 16'h0060);
    i_host.wr(25'h14B86, 16'h0003);
    chk(read_config_reg, 16'hA5C3);
    chk(rs, 4'h1);
    $display("lock and config done");
  endtask : t_lock
  task automatic t_buf();
    logic [15:0] s[2] = '{16'h00E8, 16'h00EB};
    int          n0;
    for (int i = 0; i < 2; i++) begin
      n0 = wr_n;
      i_host.wr(25'h3000, s[i]);
      if (i == 1) i_host.wr(25'h3000, 16'h0012);
      i_host.wr(25'h3000, 16'h0001);
      i_host.wr(25'h3000, 16'hA5A5);
      i_host.wr(25'h3001, 16'h5A5A);
      chk(wr_n - n0, 2);
      chk(op_data, 16'h5A5A);
      i_host.wr(25'h3001, 16'h00D0);
      chk(kind, 5'h02);
      chk(st[7], 1'b0);
      chk(rs, 4'h2);
      wait_ready();
      chk(st, 8'h80);
    end
    chk(sub, 16'h0012);
    $display("buffer and extended done");
  endtask : t_buf
  task automatic t_rst();
    int n0;
    i_host.wr(25'h8000, 16'h0020);
    i_host.wr(25'h8000, 16'h00D0);
    #1 rst_n_i = 1'b0;
    repeat (2) @(posedge clock_i);
    chk(dq_oe, 1'b0);
    #1 rst_n_i = 1'b1;
    repeat (4) @(posedge clock_i);
    chk(st, 8'h80);
    chk(rs, 4'h1);
    n0 = wr_n;
    i_host.wr(25'h5000, 16'h0080);
    i_host.wr(25'h5000, 16'h00D0);
    i_host.wr(25'h5004, 16'h00FF);
    chk(ff, 1'b1);
    chk(rs, 4'h2);
    chk(wr_n - n0, 1);
    chk(op_addr, 25'h5004);
    $display("reset abort done");
  endtask : t_rst
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  initial begin
    #(25 * 20000);
    bad_count++;
    results();
  end
  initial begin
    repeat (20) @(posedge clock_i);
    #1 rst_n_i = 1'b1;
    repeat (4) @(posedge clock_i);
    chk(st, 8'h80);
    t_reads();
    t_seq_err();
    t_ops();
    t_susp();
    t_lock();
    t_buf();
    t_rst();
    results();
  end
endmodule : tb
